// file: bspb_parser.sv
// Boot stream block parser: header decode, body load, zero fill, init call, final jump.
// Assumes stream bytes and memory writes share clk; call_return comes from the core.
`timescale 1ns/1ps
module bspb_parser
  import bspb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Boot stream in
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  output logic             in_ready,
  // Memory write port
  output logic             mem_valid,
  output logic [31:0]      mem_addr,
  output logic [7:0]       mem_data,
  input  wire logic        mem_ready,
  // Boot mode straps
  input  wire logic        twi_boot,
  input  wire logic        slave_host_boot,
  // Init block call
  output logic             call_req,
  output logic [31:0]      call_addr,
  input  wire logic        call_return,
  // Completion and status
  output logic             boot_done,
  output logic [31:0]      jump_addr,
  output logic             super_lowest,
  output logic             comp_unsupported,
  output logic             rsv_dropped,
  output logic             host_hold_off,
  output logic [5:0]       host_hold_off_pin
);
  bspb_wr_if w_if ();
  bspb_wr_if m_if ();

  bspb_state_t st_q;
  bspb_state_t st_d;
  logic [79:0] hdr_q;
  logic [3:0]  idx_q;
  logic [31:0] addr_q;
  logic [31:0] cnt_q;
  logic [15:0] flag_q;
  logic        wr_valid_q;
  logic [31:0] wr_addr_q;
  logic [7:0]  wr_data_q;
  logic        in_ready_q;
  logic        take;
  logic        wr_fire;
  logic        slot_free;
  logic        zero_step;
  logic        body_last;
  logic [79:0] new_hdr;
  logic [15:0] new_flag;
  logic        hdr_end;
  logic        in_rsv;
  logic        skip_wr;
  logic        do_wr;
  logic        wr_valid_d;
  logic        in_ready_d;
  logic [2:0]  twi_sync_q;
  logic [2:0]  shb_sync_q;
  logic        twi_mode_q;
  logic        shb_mode_q;

  // Strap pins cross in through three flops; a level counts once the last two
  // agree, so a strap moved during reset has settled before the first body byte
  always_ff @(posedge clk) begin
    twi_sync_q <= {twi_sync_q[1:0], twi_boot};
    shb_sync_q <= {shb_sync_q[1:0], slave_host_boot};
    if (twi_sync_q[2] == twi_sync_q[1]) twi_mode_q <= twi_sync_q[1];
    if (shb_sync_q[2] == shb_sync_q[1]) shb_mode_q <= shb_sync_q[1];
  end

  assign take      = in_valid && in_ready_q;
  assign wr_fire   = wr_valid_q && w_if.ready;
  assign slot_free = !wr_valid_q || wr_fire;
  // Header bytes shift in from the top, so byte 0 ends at bit 0
  assign new_hdr   = {in_data, hdr_q[79:8]};
  assign new_flag  = new_hdr[FLAG_LSB +: 16];
  assign hdr_end   = take && st_q == ST_HDR && idx_q == HDR_LAST_IX;
  assign zero_step = st_q == ST_ZERO && slot_free;
  assign body_last = cnt_q == 32'h0000_0001;
  // Reserved buffer only reachable from the final block during a two-wire boot
  assign in_rsv    = twi_mode_q && !flag_q[FLG_LAST]
                     && addr_q >= RSV_LO && addr_q <= RSV_HI;
  assign skip_wr   = flag_q[FLG_IGNORE] || flag_q[FLG_COMP] || in_rsv;
  assign do_wr     = !skip_wr && ((st_q == ST_BODY && take) || zero_step);

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_HDR: begin
        if (hdr_end) begin
          if (new_hdr[CNT_LSB +: 32] == ZERO32) begin
            st_d = (new_flag[FLG_INIT] || new_flag[FLG_LAST]) ? ST_DRAIN : ST_HDR;
          end else if (new_flag[FLG_ZERO]) begin
            st_d = ST_ZERO;
          end else begin
            st_d = ST_BODY;
          end
        end
      end
      ST_BODY, ST_ZERO: begin
        if ((take || zero_step) && body_last) begin
          st_d = (flag_q[FLG_INIT] || flag_q[FLG_LAST]) ? ST_DRAIN : ST_HDR;
        end
      end
      ST_DRAIN: begin
        // Code must be in memory before it is called or jumped to
        if (!wr_valid_q && !m_if.valid) begin
          if (flag_q[FLG_INIT]) begin
            st_d = ST_CALL;
          end else begin
            st_d = ST_DONE;
          end
        end
      end
      ST_CALL: begin
        // Resumes only when the called code returns
        if (call_return) begin
          st_d = flag_q[FLG_LAST] ? ST_DONE : ST_HDR;
        end
      end
      default: st_d = st_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) st_q <= ST_HDR;
    else     st_q <= st_d;
  end

  // Header capture
  always_ff @(posedge clk) begin
    if (rst) begin
      hdr_q  <= '0;
      idx_q  <= 4'h0;
      addr_q <= ZERO32;
      cnt_q  <= ZERO32;
      flag_q <= 16'h0000;
    end else if (st_q == ST_HDR && take) begin
      hdr_q <= new_hdr;
      idx_q <= hdr_end ? 4'h0 : idx_q + 4'h1;
      if (hdr_end) begin
        addr_q <= new_hdr[ADDR_LSB +: 32];
        cnt_q  <= new_hdr[CNT_LSB +: 32];
        flag_q <= new_flag;
      end
    end else if ((st_q == ST_BODY && take) || zero_step) begin
      addr_q <= addr_q + 32'h0000_0001;
      cnt_q  <= cnt_q - 32'h0000_0001;
    end
  end

  // Write staging register in front of the buffer
  assign wr_valid_d = do_wr || (wr_valid_q && !wr_fire);
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_valid_q <= 1'b0;
      wr_addr_q  <= ZERO32;
      wr_data_q  <= ZERO8;
    end else begin
      wr_valid_q <= wr_valid_d;
      if (do_wr) begin
        wr_addr_q <= addr_q;
        wr_data_q <= (st_q == ST_ZERO) ? ZERO8 : in_data;
      end
    end
  end

  // Registered ready; body bytes wait for a free staging slot, so the rate is
  // one byte every two cycles there, traded for a flop-driven ready
  assign in_ready_d = st_d == ST_HDR
                      || (st_d == ST_BODY && !(st_q == ST_BODY && take) && !wr_valid_d);
  always_ff @(posedge clk) begin
    if (rst) in_ready_q <= 1'b0;
    else     in_ready_q <= in_ready_d;
  end

  // Host hold-off pin and its level
  always_ff @(posedge clk) begin
    if (rst) begin
      host_hold_off     <= 1'b0;
      host_hold_off_pin <= 6'h00;
    end else begin
      host_hold_off <= shb_mode_q && !in_ready_d;
      if (hdr_end) host_hold_off_pin <= new_flag[FLG_HOLD_HI:FLG_HOLD_LO];
    end
  end

  // Init call request
  always_ff @(posedge clk) begin
    if (rst) begin
      call_req  <= 1'b0;
      call_addr <= ZERO32;
    end else begin
      call_req <= st_d == ST_CALL;
      if (hdr_end) call_addr <= new_hdr[ADDR_LSB +: 32];
    end
  end

  // Completion and error flags, sticky until reset
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_done        <= 1'b0;
      jump_addr        <= ZERO32;
      super_lowest     <= 1'b0;
      comp_unsupported <= 1'b0;
      rsv_dropped      <= 1'b0;
    end else begin
      if (st_d == ST_DONE && st_q != ST_DONE) begin
        boot_done    <= 1'b1;
        super_lowest <= 1'b1;
        jump_addr    <= flag_q[FLG_PTYPE] ? JUMP_GRP1 : JUMP_GRP0;
      end
      if (hdr_end && new_flag[FLG_COMP]) comp_unsupported <= 1'b1;
      if (in_rsv && !flag_q[FLG_IGNORE] && ((st_q == ST_BODY && take) || zero_step))
        rsv_dropped <= 1'b1;
    end
  end

  assign w_if.valid = wr_valid_q;
  assign w_if.addr  = wr_addr_q;
  assign w_if.data  = wr_data_q;
  assign m_if.ready = mem_ready;

  bspb_wr_buf u_buf (
    .clk (clk),
    .rst (rst),
    .wi  (w_if),
    .wo  (m_if)
  );

  assign in_ready  = in_ready_q;
  assign mem_valid = m_if.valid;
  assign mem_addr  = m_if.addr;
  assign mem_data  = m_if.data;

  // Checks
  hdr_ten_a: assert property (@(posedge clk) disable iff (rst)
    st_q != ST_HDR |-> idx_q == 4'h0)
    else $error("header count not restarted");
  addr_field_a: assert property (@(posedge clk) disable iff (rst)
    hdr_end |=> addr_q == $past(new_hdr[31:0])) else $error("address field wrong");
  cnt_field_a: assert property (@(posedge clk) disable iff (rst)
    hdr_end |=> cnt_q == $past(new_hdr[63:32])) else $error("count field wrong");
  zero_noread_a: assert property (@(posedge clk) disable iff (rst)
    st_q == ST_ZERO |-> !in_ready_q) else $error("zero block reads stream");
  zero_data_a: assert property (@(posedge clk) disable iff (rst)
    do_wr && st_q == ST_ZERO |=> wr_data_q == ZERO8) else $error("zero fill not zero");
  jump_sel_a: assert property (@(posedge clk) disable iff (rst)
    $rose(boot_done) |-> jump_addr == ($past(flag_q[FLG_PTYPE]) ? JUMP_GRP1 : JUMP_GRP0))
    else $error("jump target wrong");
  call_hold_a: assert property (@(posedge clk) disable iff (rst)
    call_req && !call_return |=> call_req) else $error("call dropped early");
  call_resume_a: assert property (@(posedge clk) disable iff (rst)
    st_q == ST_CALL && call_return |=> st_q != ST_CALL) else $error("no resume");
  skip_nowr_a: assert property (@(posedge clk) disable iff (rst)
    skip_wr && !wr_valid_q |=> !wr_valid_q) else $error("skipped block written");
  hold_level_a: assert property (@(posedge clk) disable iff (rst)
    slave_host_boot && in_ready |-> ##1 !host_hold_off || !in_ready)
    else $error("hold-off while ready");

  cov_init_c:  cover property (@(posedge clk) st_q == ST_CALL ##[1:50] st_q == ST_HDR);
  cov_zero_c:  cover property (@(posedge clk) st_q == ST_ZERO ##1 st_q == ST_HDR);
  cov_done_c:  cover property (@(posedge clk) $rose(boot_done));
  cov_stall_c: cover property (@(posedge clk) (mem_valid && !mem_ready) [*3]);
endmodule

// file: bspb_pkg.sv
// Constants shared by the boot stream block parser and its write buffer.
// Assumes a byte-wide boot stream and a byte-wide memory write port.
package bspb_pkg;
  // Header layout: address, count, flag word
  localparam int          HDR_BYTES   = 10;
  localparam logic [3:0]  HDR_LAST_IX = 4'h9;
  localparam int          ADDR_LSB    = 0;
  localparam int          CNT_LSB     = 32;
  localparam int          FLAG_LSB    = 64;
  // Flag word bit positions
  localparam int          FLG_ZERO    = 0;
  localparam int          FLG_PTYPE   = 1;
  localparam int          FLG_INIT    = 3;
  localparam int          FLG_IGNORE  = 4;
  localparam int          FLG_HOLD_LO = 5;
  localparam int          FLG_HOLD_HI = 10;
  localparam int          FLG_COMP    = 13;
  localparam int          FLG_LAST    = 15;
  // Final jump targets
  localparam logic [31:0] JUMP_GRP0   = 32'hffa0_0000;
  localparam logic [31:0] JUMP_GRP1   = 32'hffa0_8000;
  // Range kept for the boot logic itself during a two-wire boot
  localparam logic [31:0] RSV_LO      = 32'hff90_3f00;
  localparam logic [31:0] RSV_HI      = 32'hff90_3fff;
  // Reset values and write buffer depth
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  localparam logic [7:0]  ZERO8       = 8'h00;
  localparam logic [1:0]  FIFO_DEPTH  = 2'h2;

  typedef enum logic [2:0] {
    ST_HDR   = 3'b000,
    ST_BODY  = 3'b001,
    ST_ZERO  = 3'b010,
    ST_DRAIN = 3'b011,
    ST_CALL  = 3'b100,
    ST_DONE  = 3'b101
  } bspb_state_t;
endpackage

// file: bspb_wr_if.sv
// Memory write channel between the parser and its two-entry buffer.
// Assumes one clock; a word moves when valid and ready are both high.
`timescale 1ns/1ps
interface bspb_wr_if;
  logic        valid;
  logic        ready;
  logic [31:0] addr;
  logic [7:0]  data;
  modport src (output valid, output addr, output data, input ready);
  modport snk (input valid, input addr, input data, output ready);
endinterface

// file: bspb_wr_buf.sv
// Two-entry write buffer with valid and ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module bspb_wr_buf
  import bspb_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Filling and draining sides
  bspb_wr_if.snk    wi,
  bspb_wr_if.src    wo
);
  logic [39:0] mem_q [2];
  logic        wp_q;
  logic        rp_q;
  logic [1:0]  cnt_q;
  logic        full_q;
  logic        vld_q;
  logic        push;
  logic        pop;
  logic [1:0]  cnt_d;

  assign push = wi.valid && !full_q;
  assign pop  = vld_q && wo.ready;
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  // Storage and pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= {wi.addr, wi.data};
        wp_q        <= ~wp_q;
      end
      if (pop) rp_q <= ~rp_q;
    end
  end

  // Flags kept as flops so the block outputs stay registered
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= 2'h0;
      full_q <= 1'b0;
      vld_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      full_q <= (cnt_d == FIFO_DEPTH);
      vld_q  <= (cnt_d != 2'h0);
    end
  end

  assign wi.ready = !full_q;
  assign wo.valid = vld_q;
  assign wo.addr  = mem_q[rp_q][39:8];
  assign wo.data  = mem_q[rp_q][7:0];

  full_honest_a: assert property (@(posedge clk) disable iff (rst)
    full_q |-> cnt_q == FIFO_DEPTH) else $error("buffer full flag wrong");
endmodule

// file: bspb_src_model.sv
// Boot source model: hands the parser its stream one byte at a time.
// Assumes the bench pushes the whole stream; drives just after falling edges.
`timescale 1ns/1ps
module bspb_src_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Pacing and hold-off
  input  wire logic       slow,
  input  wire logic       host_hold_off,
  // Stream out
  input  wire logic       in_ready,
  output logic            in_valid,
  output logic [7:0]      in_data
);
  logic [7:0] q[$];
  logic       taken_q;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  initial begin
    in_valid = 1'b0;
    in_data  = 8'h00;
    taken_q  = 1'b0;
  end

  // Record the handshake at the sampling edge
  always @(posedge clk) begin
    taken_q <= in_valid && in_ready;
  end

  // Hold a byte until taken; no new byte while held off
  always @(negedge clk) begin
    if (taken_q) begin
      void'(q.pop_front());
    end
    if (in_valid && !taken_q) begin
      in_valid = 1'b1;
    end else if (q.size() > 0 && !host_hold_off && !(taken_q && slow) && !rst) begin
      in_valid = 1'b1;
      in_data  = q[0];
    end else begin
      in_valid = 1'b0;
      in_data  = ~in_data; // Released line keeps toggling so stale data is never trusted
    end
  end
endmodule

// file: boot_stream_block_parser_tb_top.sv
// Testbench for the boot stream block parser: streams blocks, collects writes.
// Assumes the parser holds its own two-entry buffer and its assertions.
`timescale 1ns/1ps
module boot_stream_block_parser_tb_top;
  import bspb_pkg::*;
  logic        clk, rst, slow, mem_ready, twi_boot, slave_host_boot, call_return;
  logic        in_valid, in_ready, mem_valid, call_req, boot_done, super_lowest;
  logic        comp_unsupported, rsv_dropped, host_hold_off;
  logic [7:0]  in_data, mem_data;
  logic [31:0] mem_addr, call_addr, jump_addr;
  logic [5:0]  host_hold_off_pin;
  logic [39:0] exp_q[$], got_q[$];
  int          num_errors, checks, cyc, cwait, calls;

  bspb_parser bspb_parser_inst (.clk(clk), .rst(rst), .in_valid(in_valid),
    .in_data(in_data), .in_ready(in_ready), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_ready(mem_ready), .twi_boot(twi_boot),
    .slave_host_boot(slave_host_boot), .call_req(call_req), .call_addr(call_addr),
    .call_return(call_return), .boot_done(boot_done), .jump_addr(jump_addr),
    .super_lowest(super_lowest), .comp_unsupported(comp_unsupported),
    .rsv_dropped(rsv_dropped), .host_hold_off(host_hold_off),
    .host_hold_off_pin(host_hold_off_pin));
  bspb_src_model bspb_src_model_inst (.clk(clk), .rst(rst), .slow(slow),
    .host_hold_off(host_hold_off), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data));

  always #10 clk = ~clk;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Queue one block; the reserved window only drops bytes of non-final blocks
  task automatic blk(input logic [31:0] a, input logic [31:0] n, input logic [15:0] f);
    logic [79:0] h;
    logic [7:0]  b;
    logic [31:0] ad;
    h = {f, n, a};
    for (int i = 0; i < 10; i++) bspb_src_model_inst.push(h[8*i +: 8]);
    for (int i = 0; i < int'(n); i++) begin
      b  = 8'h5a ^ i[7:0] ^ a[7:0];
      ad = a + 32'(i);
      if (!f[FLG_ZERO]) bspb_src_model_inst.push(b);
      if (!f[FLG_IGNORE] && !f[FLG_COMP]
          && !(twi_boot && !f[FLG_LAST] && ad >= RSV_LO && ad <= RSV_HI))
        exp_q.push_back({ad, f[FLG_ZERO] ? 8'h00 : b});
    end
  endtask

  // Bounded wait for the final jump
  task automatic wait_done;
    int k;
    k = 0;
    while (boot_done !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000) begin
      num_errors++;
      report_and_stop;
    end
    repeat (4) @(negedge clk);
  endtask

  task automatic cmp_writes;
    chk(40'(got_q.size()), 40'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i]);
  endtask

  // Collect accepted writes; no stream byte may be taken during a call
  always @(posedge clk) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) got_q.push_back({mem_addr, mem_data});
    if (call_req === 1'b1 && in_valid === 1'b1 && in_ready === 1'b1) chk(40'h1, 40'h0);
  end

  // Memory stalls 6 of every 16 cycles so the buffer fills and refuses
  always @(negedge clk) begin
    cyc++;
    mem_ready <= (cyc % 16) < 10;
  end

  // Init code returns after a few cycles
  always @(negedge clk) begin
    if (call_req === 1'b1) begin
      cwait++;
      call_return <= (cwait == 4);
      if (cwait == 4) begin
        calls++;
        chk({8'h00, call_addr}, {8'h00, 32'hff80_0000});
      end
    end else begin
      cwait = 0;
      call_return <= 1'b0;
    end
  end

  initial begin
    #2_000_000;
    num_errors++;
    report_and_stop;
  end

  initial begin
    clk = 1'b0; rst = 1'b1; slow = 1'b0; mem_ready = 1'b0; call_return = 1'b0;
    twi_boot = 1'b1; slave_host_boot = 1'b1;
    num_errors = 0; checks = 0; cyc = 0; cwait = 0; calls = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({36'h0, boot_done, mem_valid, call_req, rsv_dropped}, 40'h0);
    // Two-wire, host-paced, fast source
    blk(32'h0000_1000, 32'h0000_0003, 16'h0000);
    blk(32'h0000_1100, 32'h0000_0004, 16'h0001);
    blk(32'hff80_0000, 32'h0000_0001, 16'h0008);
    blk(32'h0000_1200, 32'h0000_0002, 16'h0010);
    blk(32'h0000_1300, 32'h0000_0002, 16'h2000);
    blk(32'hff90_3ffe, 32'h0000_0003, 16'h0000);
    blk(32'h0000_1400, 32'h0000_0000, 16'h0000);
    blk(32'hff90_3f00, 32'h0000_0002, 16'h8142);
    wait_done;
    cmp_writes;
    chk({8'h00, jump_addr}, {8'h00, JUMP_GRP1});
    chk({34'h0, super_lowest, comp_unsupported, rsv_dropped, in_ready, 2'(calls)}, 40'h39);
    chk({39'h0, host_hold_off}, 40'h1);
    chk({34'h0, host_hold_off_pin}, 40'h0a);
    // Second boot after reset: slow source, other processor group
    rst = 1'b1;
    twi_boot = 1'b0;
    slave_host_boot = 1'b0;
    slow = 1'b1;
    repeat (10) @(negedge clk);
    exp_q.delete();
    got_q.delete();
    rst = 1'b0;
    @(negedge clk);
    blk(32'h0000_2000, 32'h0000_0002, 16'h0000);
    blk(32'hff90_3f10, 32'h0000_0001, 16'h8000);
    wait_done;
    cmp_writes;
    chk({8'h00, jump_addr}, {8'h00, JUMP_GRP0});
    chk({36'h0, super_lowest, comp_unsupported, rsv_dropped, host_hold_off}, 40'h8);
    report_and_stop;
  end
endmodule
